// file: core/mcsr_pkg.sv
// package: register map, widths, reset values and field positions of the metering register bank
package mcsr_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // register addresses as printed
  localparam logic [15:0] ADDR_FILTER_DISABLE    = 16'h4389;
  localparam logic [15:0] ADDR_CURRENT_PEAK      = 16'hE500;
  localparam logic [15:0] ADDR_VOLTAGE_PEAK      = 16'hE501;
  localparam logic [15:0] ADDR_OVERCURRENT_STAT  = 16'hE600;
  localparam logic [15:0] ADDR_LINE_PERIOD       = 16'hE607;
  localparam logic [15:0] ADDR_NO_LOAD_STATUS    = 16'hE608;
  localparam logic [15:0] ADDR_RSVD_LO           = 16'hE609;
  localparam logic [15:0] ADDR_RSVD_HI           = 16'hE60B;
  localparam logic [15:0] ADDR_LINE_CYCLE_COUNT  = 16'hE60C;
  localparam logic [15:0] ADDR_ZERO_CROSS_TOUT   = 16'hE60D;
  localparam logic [15:0] ADDR_COMPUTATION_MODE  = 16'hE60E;
  localparam logic [15:0] ADDR_INPUT_GAIN        = 16'hE60F;
  localparam logic [15:0] ADDR_POWER_SIGN        = 16'hE617;
  localparam logic [15:0] ADDR_MAIN_CONFIG       = 16'hE618;
  localparam logic [15:0] ADDR_MEASUREMENT_SEL   = 16'hE700;
  localparam logic [15:0] ADDR_ACCUMULATION_SEL  = 16'hE701;
  localparam logic [15:0] ADDR_LINE_ACCUM_SEL    = 16'hE702;
  localparam logic [15:0] ADDR_PEAK_HALF_CYCLES  = 16'hE703;
  localparam logic [15:0] ADDR_SAG_HALF_CYCLES   = 16'hE704;
  localparam logic [15:0] ADDR_CAPTURE_PORT_CFG  = 16'hE706;
  localparam logic [15:0] ADDR_DIE_VERSION       = 16'hE707;
  localparam logic [15:0] ADDR_WRITE_PROTECTION  = 16'hE7E3;
  localparam logic [15:0] ADDR_SELECT_ACK_PIN    = 16'hEBFF;
  localparam logic [15:0] ADDR_SECONDARY_CONFIG  = 16'hEC01;

  // reset values
  localparam logic [23:0] RST_FILTER_DISABLE   = 24'h00_0000;
  localparam logic [15:0] RST_LINE_CYCLE_COUNT = 16'hFFFF;
  localparam logic [15:0] RST_ZERO_CROSS_TOUT  = 16'hFFFF;
  localparam logic [15:0] RST_COMPUTATION_MODE = 16'h01FF;
  localparam logic [15:0] RST_INPUT_GAIN       = 16'h0000;
  localparam logic [15:0] RST_MAIN_CONFIG      = 16'h0000;
  localparam logic [7:0]  RST_MEASUREMENT_SEL  = 8'h1C;
  localparam logic [7:0]  RST_ACCUMULATION_SEL = 8'h00;
  localparam logic [7:0]  RST_LINE_ACCUM_SEL   = 8'h78;
  localparam logic [7:0]  RST_BYTE_ZERO        = 8'h00;
  // arbitrary neutral die version value
  localparam logic [7:0]  RST_DIE_VERSION      = 8'h01;
  // shared select / capture-ack pin idles high
  localparam logic        RST_SELECT_ACK_PIN   = 1'b1;

  // transfer widths and field positions
  localparam int PEAK_VAL_W   = 24;
  localparam int PAIRS        = 3;
  localparam int PEAK_PAIR_LSB = 24;
  localparam int OC_PAIR_LSB   = 3;
  localparam int NO_LOAD_W     = 10;
  localparam int NO_LOAD_CH    = 6;

  // transfer width codes driven with read data
  localparam logic [1:0] XFER_8  = 2'd0;
  localparam logic [1:0] XFER_16 = 2'd1;
  localparam logic [1:0] XFER_32 = 2'd2;

endpackage

// file: core/mcsr_extend.sv
// one register read lane: zero padding or sign extension of a narrow value to 32 bits
`timescale 1ns/1ps
module mcsr_extend
  import mcsr_pkg::*;
#(
  parameter int SRC_W = 24
)(
  input  wire logic [SRC_W-1:0]  i_value,
  input  wire logic              i_sign_extend,
  output logic      [DATA_W-1:0] o_word
);

  // =====================================================
  // widen
  always_comb
  begin
    if (i_sign_extend)
      o_word = {{(DATA_W-SRC_W){i_value[SRC_W-1]}}, i_value};
    else
      o_word = {{(DATA_W-SRC_W){1'b0}}, i_value};
  end

endmodule

// file: core/mcsr_regs.sv
// register bank of the metering configuration and status registers
`timescale 1ns/1ps
module mcsr_regs
  import mcsr_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  // register port from the serial interface
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [ADDR_W-1:0]     i_reg_addr,
  input  wire logic [DATA_W-1:0]     i_reg_wdata,
  input  wire logic                  i_spi_active,
  output logic      [DATA_W-1:0]     o_reg_rdata,
  output logic      [1:0]            o_reg_width,
  output logic                       o_reg_rvalid,
  output logic                       o_reg_hit,
  // measurement core status inputs
  input  wire logic                  i_peak_i_load,
  input  wire logic [PEAK_VAL_W-1:0] i_peak_i_value,
  input  wire logic [PAIRS-1:0]      i_peak_i_pair,
  input  wire logic                  i_peak_v_load,
  input  wire logic [PEAK_VAL_W-1:0] i_peak_v_value,
  input  wire logic                  i_oc_event,
  input  wire logic [PAIRS-1:0]      i_oc_pair,
  input  wire logic [15:0]           i_line_period,
  input  wire logic [NO_LOAD_CH-1:0] i_no_load,
  input  wire logic [15:0]           i_power_sign,
  // configuration outputs to the core
  output logic                       o_filter_bypass,
  output logic      [15:0]           o_line_cycle_count,
  output logic      [15:0]           o_zero_cross_timeout,
  output logic      [15:0]           o_computation_mode,
  output logic      [15:0]           o_input_gain,
  output logic      [15:0]           o_main_configuration,
  output logic      [7:0]            o_measurement_select,
  output logic      [7:0]            o_accumulation_select,
  output logic      [7:0]            o_line_accum_select,
  output logic      [7:0]            o_peak_half_cycles,
  output logic      [7:0]            o_sag_half_cycles,
  output logic      [7:0]            o_capture_port_config,
  output logic      [7:0]            o_write_protection,
  output logic      [7:0]            o_secondary_configuration,
  output logic                       o_select_ack_pin
);

  // =====================================================
  // storage
  logic [23:0]           filter_disable;
  logic [PEAK_VAL_W-1:0] current_peak_value;
  logic [PAIRS-1:0]      current_peak_pair;
  logic [PEAK_VAL_W-1:0] voltage_peak_value;
  logic [PAIRS-1:0]      overcurrent_pair;
  logic [7:0]            die_version;
  logic [15:0]           line_period_s1;
  logic [15:0]           line_period_s2;
  logic [15:0]           line_period_s3;
  logic [15:0]           line_period_hold;
  logic [NO_LOAD_CH-1:0] no_load_s1;
  logic [NO_LOAD_CH-1:0] no_load_s2;
  logic [15:0]           power_sign_s1;
  logic [15:0]           power_sign_s2;
  logic [DATA_W-1:0]     next_rdata;
  logic [1:0]            next_width;
  logic                  next_hit;
  logic                  wr_reserved;
  logic [DATA_W-1:0]     peak_i_word;
  logic [DATA_W-1:0]     peak_v_word;

  // =====================================================
  // status inputs from analog-side logic are resynchronised; the peak
  // and overcurrent captures come from the same clock and need none
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      line_period_s1 <= '0;
      line_period_s2 <= '0;
      line_period_s3 <= '0;
      no_load_s1     <= '0;
      no_load_s2     <= '0;
      power_sign_s1  <= '0;
      power_sign_s2  <= '0;
    end
    else
    begin
      line_period_s1 <= i_line_period;
      line_period_s2 <= line_period_s1;
      line_period_s3 <= line_period_s2;
      no_load_s1     <= i_no_load;
      no_load_s2     <= no_load_s1;
      power_sign_s1  <= i_power_sign;
      power_sign_s2  <= power_sign_s1;
    end
  end

  // =====================================================
  // the period is a whole word: a bit-wise resync can tear it while it
  // moves, so it is only taken once two synced samples agree
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      line_period_hold <= '0;
    else if (line_period_s2 == line_period_s3)
      line_period_hold <= line_period_s2;
  end

  // =====================================================
  // peak captures, read-only to the host
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      current_peak_value <= '0;
      current_peak_pair  <= '0;
      voltage_peak_value <= '0;
    end
    else
    begin
      if (i_peak_i_load)
      begin
        current_peak_value <= i_peak_i_value;
        current_peak_pair  <= i_peak_i_pair;
      end
      if (i_peak_v_load)
        voltage_peak_value <= i_peak_v_value;
    end
  end

  // =====================================================
  // overcurrent source pair, latched per event
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      overcurrent_pair <= '0;
    else if (i_oc_event)
      overcurrent_pair <= i_oc_pair;
  end

  // =====================================================
  // writes; the reserved window is gated off before the case and read-only
  // addresses fall through it untouched, so they can never corrupt state
  assign wr_reserved = (i_reg_addr >= ADDR_RSVD_LO) && (i_reg_addr <= ADDR_RSVD_HI);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      filter_disable            <= RST_FILTER_DISABLE;
      o_line_cycle_count        <= RST_LINE_CYCLE_COUNT;
      o_zero_cross_timeout      <= RST_ZERO_CROSS_TOUT;
      o_computation_mode        <= RST_COMPUTATION_MODE;
      o_input_gain              <= RST_INPUT_GAIN;
      o_main_configuration      <= RST_MAIN_CONFIG;
      o_measurement_select      <= RST_MEASUREMENT_SEL;
      o_accumulation_select     <= RST_ACCUMULATION_SEL;
      o_line_accum_select       <= RST_LINE_ACCUM_SEL;
      o_peak_half_cycles        <= RST_BYTE_ZERO;
      o_sag_half_cycles         <= RST_BYTE_ZERO;
      o_capture_port_config     <= RST_BYTE_ZERO;
      die_version               <= RST_DIE_VERSION;
      o_write_protection        <= RST_BYTE_ZERO;
      o_secondary_configuration <= RST_BYTE_ZERO;
      o_select_ack_pin          <= RST_SELECT_ACK_PIN;     // idle high until host drives it
    end
    else if (i_reg_wr && !wr_reserved)
    begin
      unique case (i_reg_addr)
        ADDR_FILTER_DISABLE:   filter_disable            <= i_reg_wdata[23:0];
        ADDR_LINE_CYCLE_COUNT: o_line_cycle_count        <= i_reg_wdata[15:0];
        ADDR_ZERO_CROSS_TOUT:  o_zero_cross_timeout      <= i_reg_wdata[15:0];
        ADDR_COMPUTATION_MODE: o_computation_mode        <= i_reg_wdata[15:0];
        ADDR_INPUT_GAIN:       o_input_gain              <= i_reg_wdata[15:0];
        ADDR_MAIN_CONFIG:      o_main_configuration      <= i_reg_wdata[15:0];
        ADDR_MEASUREMENT_SEL:  o_measurement_select      <= i_reg_wdata[7:0];
        ADDR_ACCUMULATION_SEL: o_accumulation_select     <= i_reg_wdata[7:0];
        ADDR_LINE_ACCUM_SEL:   o_line_accum_select       <= i_reg_wdata[7:0];
        ADDR_PEAK_HALF_CYCLES: o_peak_half_cycles        <= i_reg_wdata[7:0];
        ADDR_SAG_HALF_CYCLES:  o_sag_half_cycles         <= i_reg_wdata[7:0];
        ADDR_CAPTURE_PORT_CFG: o_capture_port_config     <= i_reg_wdata[7:0];
        ADDR_DIE_VERSION:      die_version               <= i_reg_wdata[7:0];
        ADDR_WRITE_PROTECTION: o_write_protection        <= i_reg_wdata[7:0];
        ADDR_SECONDARY_CONFIG: o_secondary_configuration <= i_reg_wdata[7:0];
        ADDR_SELECT_ACK_PIN:
        begin
          if (i_spi_active)
            o_select_ack_pin <= i_reg_wdata[0];
        end
        default: ;
      endcase
    end
  end

  // =====================================================
  // filter bypass is one global bit, no per-channel choice
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_filter_bypass <= 1'b0;
    else
      o_filter_bypass <= |filter_disable;
  end

  // =====================================================
  // read lanes; both peaks are unsigned so they pad with zero
  mcsr_extend #(
    .SRC_W (PEAK_VAL_W)
  ) u_ext_i (
    .i_value       (current_peak_value),
    .i_sign_extend (1'b0),
    .o_word        (peak_i_word)
  );

  mcsr_extend #(
    .SRC_W (PEAK_VAL_W)
  ) u_ext_v (
    .i_value       (voltage_peak_value),
    .i_sign_extend (1'b0),
    .o_word        (peak_v_word)
  );

  // =====================================================
  // read mux with transfer width per register
  always_comb
  begin
    next_rdata = '0;
    next_width = XFER_8;
    next_hit   = 1'b1;
    unique case (i_reg_addr)
      ADDR_FILTER_DISABLE:
      begin
        next_rdata = {8'h00, filter_disable};
        next_width = XFER_32;
      end
      ADDR_CURRENT_PEAK:
      begin
        next_rdata = peak_i_word;
        next_rdata[PEAK_PAIR_LSB +: PAIRS] = current_peak_pair;
        next_width = XFER_32;
      end
      ADDR_VOLTAGE_PEAK:
      begin
        next_rdata = peak_v_word;
        next_width = XFER_32;
      end
      ADDR_OVERCURRENT_STAT:
      begin
        next_rdata[OC_PAIR_LSB +: PAIRS] = overcurrent_pair;
        next_width = XFER_16;
      end
      ADDR_LINE_PERIOD:
      begin
        next_rdata[15:0] = line_period_hold;
        next_width = XFER_16;
      end
      ADDR_NO_LOAD_STATUS:
      begin
        next_rdata[NO_LOAD_CH-1:0] = no_load_s2;
        next_width = XFER_16;
      end
      ADDR_LINE_CYCLE_COUNT:
      begin
        next_rdata[15:0] = o_line_cycle_count;
        next_width = XFER_16;
      end
      ADDR_ZERO_CROSS_TOUT:
      begin
        next_rdata[15:0] = o_zero_cross_timeout;
        next_width = XFER_16;
      end
      ADDR_COMPUTATION_MODE:
      begin
        next_rdata[15:0] = o_computation_mode;
        next_width = XFER_16;
      end
      ADDR_INPUT_GAIN:
      begin
        next_rdata[15:0] = o_input_gain;
        next_width = XFER_16;
      end
      ADDR_POWER_SIGN:
      begin
        next_rdata[15:0] = power_sign_s2;
        next_width = XFER_16;
      end
      ADDR_MAIN_CONFIG:
      begin
        next_rdata[15:0] = o_main_configuration;
        next_width = XFER_16;
      end
      ADDR_MEASUREMENT_SEL:  next_rdata[7:0] = o_measurement_select;
      ADDR_ACCUMULATION_SEL: next_rdata[7:0] = o_accumulation_select;
      ADDR_LINE_ACCUM_SEL:   next_rdata[7:0] = o_line_accum_select;
      ADDR_PEAK_HALF_CYCLES: next_rdata[7:0] = o_peak_half_cycles;
      ADDR_SAG_HALF_CYCLES:  next_rdata[7:0] = o_sag_half_cycles;
      ADDR_CAPTURE_PORT_CFG: next_rdata[7:0] = o_capture_port_config;
      ADDR_DIE_VERSION:      next_rdata[7:0] = die_version;
      ADDR_WRITE_PROTECTION: next_rdata[7:0] = o_write_protection;
      ADDR_SELECT_ACK_PIN:   next_rdata[0]   = o_select_ack_pin;
      ADDR_SECONDARY_CONFIG: next_rdata[7:0] = o_secondary_configuration;
      default:               next_hit = 1'b0;  // unmapped reads return zero
    endcase
  end

  // =====================================================
  // registered read answer, one cycle after the strobe
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata  <= '0;
      o_reg_width  <= XFER_8;
      o_reg_rvalid <= 1'b0;
      o_reg_hit    <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
      begin
        o_reg_rdata <= next_rdata;
        o_reg_width <= next_width;
        o_reg_hit   <= next_hit;
      end
    end
  end

endmodule

// file: tb/mcsr_regs_chk.sv
// checker: port-level assertions of the metering register bank
`timescale 1ns/1ps
module mcsr_regs_chk
  import mcsr_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic              i_spi_active,
  input wire logic [DATA_W-1:0] o_reg_rdata,
  input wire logic              o_reg_rvalid,
  input wire logic              o_filter_bypass,
  input wire logic [15:0]       o_line_cycle_count,
  input wire logic [15:0]       o_input_gain,
  input wire logic [7:0]        o_peak_half_cycles,
  input wire logic [7:0]        o_sag_half_cycles,
  input wire logic              o_select_ack_pin
);
  // one clock domain; nothing is judged while reset is high
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ====================
  // filter bypass, two cycles behind the write
  chk_bypass_zero:
    assert property (i_reg_wr && i_reg_addr == ADDR_FILTER_DISABLE && !(|i_reg_wdata[23:0])
      |-> ##2 !o_filter_bypass) else $error("filters bypassed by a zero word");
  chk_bypass_nonzero:
    assert property (i_reg_wr && i_reg_addr == ADDR_FILTER_DISABLE && (|i_reg_wdata[23:0])
      |-> ##2 o_filter_bypass) else $error("filters kept by a nonzero word");

  // ====================
  // reserved upper bits of the status words, and the low bits of the overcurrent word
  chk_current_peak_upper:
    assert property (i_reg_rd && i_reg_addr == ADDR_CURRENT_PEAK
      |=> o_reg_rvalid && o_reg_rdata[31:27] == 5'h00) else $error("current peak top bits");
  chk_voltage_peak_upper:
    assert property (i_reg_rd && i_reg_addr == ADDR_VOLTAGE_PEAK
      |=> o_reg_rvalid && o_reg_rdata[31:24] == 8'h00) else $error("voltage peak top byte");
  chk_oc_low_zero:
    assert property (i_reg_rd && i_reg_addr == ADDR_OVERCURRENT_STAT
      |=> o_reg_rdata[2:0] == 3'h0 && o_reg_rdata[31:6] == 26'h000_0000)
      else $error("overcurrent word reserved bits");

  // ====================
  // writable configuration lands one cycle after the write
  chk_line_cycle_wr:
    assert property (i_reg_wr && i_reg_addr == ADDR_LINE_CYCLE_COUNT
      |=> o_line_cycle_count == $past(i_reg_wdata[15:0])) else $error("line cycle write");
  chk_peak_cyc_wr:
    assert property (i_reg_wr && i_reg_addr == ADDR_PEAK_HALF_CYCLES
      |=> o_peak_half_cycles == $past(i_reg_wdata[7:0])) else $error("peak cycles write");
  chk_sag_cyc_wr:
    assert property (i_reg_wr && i_reg_addr == ADDR_SAG_HALF_CYCLES
      |=> o_sag_half_cycles == $past(i_reg_wdata[7:0])) else $error("sag cycles write");
  chk_gain_wr:
    assert property (i_reg_wr && i_reg_addr == ADDR_INPUT_GAIN
      |=> o_input_gain == $past(i_reg_wdata[15:0])) else $error("gain write");
  chk_pin_gate:
    assert property (i_reg_wr && i_reg_addr == ADDR_SELECT_ACK_PIN |=> o_select_ack_pin ==
      ($past(i_spi_active) ? $past(i_reg_wdata[0]) : $past(o_select_ack_pin)))
      else $error("select pin write gating");
endmodule

bind mcsr_regs mcsr_regs_chk u_chk (
  .i_ref_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_spi_active,
  .o_reg_rdata, .o_reg_rvalid, .o_filter_bypass, .o_line_cycle_count, .o_input_gain,
  .o_peak_half_cycles, .o_sag_half_cycles, .o_select_ack_pin
);

// file: tb/mcsr_host.sv
// host model: serial-port host issuing single register accesses
`timescale 1ns/1ps
module mcsr_host
  import mcsr_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic [DATA_W-1:0] i_rdata,
  input  wire logic              i_rvalid,
  output logic                   o_wr,
  output logic                   o_rd,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_wdata
);
  // ====================
  // idle port at time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 32'h0000_0000;
  end

  // one write strobe; the reserved window is never written
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if (a >= ADDR_RSVD_LO && a <= ADDR_RSVD_HI)
      return;
    @(posedge i_ref_clk);
    #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_ref_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a; // released lines must not keep a stale value
    o_wdata = ~d;
  endtask

  // one read strobe; answer is registered at the taking edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
    @(posedge i_ref_clk);
    #1;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_ref_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// file: tb/testbench.sv
// testbench: register bank against a behavioural register model
`timescale 1ns/1ps
module testbench;
  import mcsr_pkg::*;
  logic              i_ref_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_spi_active;
  logic [ADDR_W-1:0] i_reg_addr;
  logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata, rv;
  logic              i_peak_i_load, i_peak_v_load, i_oc_event, vld;
  logic [23:0]       i_peak_i_value, i_peak_v_value;
  logic [2:0]        i_peak_i_pair, i_oc_pair;
  logic [15:0]       i_line_period, i_power_sign, o_line_cycle_count, o_input_gain;
  logic [5:0]        i_no_load;
  logic              o_reg_rvalid, o_reg_hit, o_filter_bypass, o_select_ack_pin;
  logic [7:0]        o_peak_half_cycles, o_sag_half_cycles, o_write_protection;
  logic [1:0]        o_reg_width;
  logic [15:0]       o_zero_cross_timeout, o_computation_mode, o_main_configuration;
  logic [7:0]        o_measurement_select, o_accumulation_select, o_line_accum_select;
  logic [7:0]        o_capture_port_config, o_secondary_configuration;
  logic [15:0]       lfsr = 16'hA399;
  int                n_errors = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int unsigned       mdl[15];
  // writable registers: address, reset value, width
  logic [15:0] rw_a[15] = '{ADDR_FILTER_DISABLE, ADDR_LINE_CYCLE_COUNT, ADDR_ZERO_CROSS_TOUT,
    ADDR_COMPUTATION_MODE, ADDR_INPUT_GAIN, ADDR_MAIN_CONFIG, ADDR_MEASUREMENT_SEL,
    ADDR_ACCUMULATION_SEL, ADDR_LINE_ACCUM_SEL, ADDR_PEAK_HALF_CYCLES, ADDR_SAG_HALF_CYCLES,
    ADDR_CAPTURE_PORT_CFG, ADDR_DIE_VERSION, ADDR_WRITE_PROTECTION, ADDR_SECONDARY_CONFIG};
  logic [31:0] rw_r[15] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_01FF, 0, 0,
    32'h0000_001C, 0, 32'h0000_0078, 0, 0, 0, {24'h00_0000, RST_DIE_VERSION}, 0, 0};
  int          rw_w[15] = '{24, 16, 16, 16, 16, 16, 8, 8, 8, 8, 8, 8, 8, 8, 8};
  logic [23:0] fv[4] = '{24'h00_0000, 24'h00_0001, 24'h80_0000, 24'h00_0000};
  logic [2:0]  ps[4] = '{3'b010, 3'b001, 3'b111, 3'b101}; // expected pin, port, data bit

  mcsr_regs dut (
    .i_ref_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_spi_active,
    .o_reg_rdata, .o_reg_width, .o_reg_rvalid, .o_reg_hit, .i_peak_i_load, .i_peak_i_value,
    .i_peak_i_pair, .i_peak_v_load, .i_peak_v_value, .i_oc_event, .i_oc_pair, .i_line_period,
    .i_no_load, .i_power_sign, .o_filter_bypass, .o_line_cycle_count,
    .o_zero_cross_timeout, .o_computation_mode, .o_input_gain, .o_main_configuration,
    .o_measurement_select, .o_accumulation_select, .o_line_accum_select,
    .o_peak_half_cycles, .o_sag_half_cycles, .o_capture_port_config, .o_write_protection,
    .o_secondary_configuration, .o_select_ack_pin
  );
  mcsr_host host (
    .i_ref_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_wr(i_reg_wr),
    .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata)
  );

  // ====================
  // 40 MHz clock and a hang guard well beyond the 180 or so cycles needed
  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rnd = {lfsr, lfsr ^ 16'h5A5A};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // read one register; word and strobe both compared
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    host.rd(a, rv, vld);
    chk(rv, e);
    chk({31'h0000_0000, vld}, 32'h0000_0001);
  endtask

  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ====================
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0]  ew;
    {i_sys_rst, i_spi_active} = 2'h3;
    {i_peak_i_load, i_peak_v_load, i_oc_event, i_peak_i_pair, i_oc_pair} = 9'h000;
    {i_peak_i_value, i_peak_v_value, i_line_period, i_power_sign, i_no_load} = 86'h0;
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_sys_rst = 1'b0;
    // reset value, random write, readback for every writable register but the select / ack pin
    for (int k = 0; k < 15; k++)
    begin
      rdchk(rw_a[k], rw_r[k]);
      d = rnd();
      host.wr(rw_a[k], d);
      mdl[k] = d & ((32'h0000_0001 << rw_w[k]) - 1);
      rdchk(rw_a[k], mdl[k]);
      ew = (rw_w[k] == 24) ? XFER_32 : ((rw_w[k] == 16) ? XFER_16 : XFER_8);
      chk({30'h0, o_reg_width}, {30'h0, ew});
      chk({31'h0000_0000, o_reg_hit}, 32'h0000_0001);
    end
    chk({16'h0000, o_line_cycle_count}, mdl[1]);
    chk({16'h0000, o_input_gain}, mdl[4]);
    chk({24'h00_0000, o_peak_half_cycles}, mdl[9]);
    chk({24'h00_0000, o_sag_half_cycles}, mdl[10]);
    chk({24'h00_0000, o_write_protection}, mdl[13]);
    // upper byte set on purpose: only the 24-bit field may count
    foreach (fv[k])
    begin
      host.wr(ADDR_FILTER_DISABLE, {8'hFF, fv[k]});
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk({31'h0000_0000, o_filter_bypass}, {31'h0000_0000, fv[k] != 24'h00_0000});
    end
    // peak and overcurrent capture per channel pair; inputs move after the load
    for (int p = 0; p < 3; p++)
    begin
      d = rnd();
      {i_peak_i_load, i_peak_v_load, i_oc_event} = 3'h7;
      {i_peak_i_value, i_peak_v_value} = {d[23:0], d[31:8]};
      {i_peak_i_pair, i_oc_pair} = {3'b001 << p, 3'b001 << p};
      @(posedge i_ref_clk);
      #1;
      {i_peak_i_load, i_peak_v_load, i_oc_event} = 3'h0;
      {i_peak_i_value, i_peak_v_value, i_peak_i_pair, i_oc_pair} = 54'h0;
      host.wr(ADDR_CURRENT_PEAK, 32'hFFFF_FFFF);
      rdchk(ADDR_CURRENT_PEAK, {5'h00, 3'b001 << p, d[23:0]});
      rdchk(ADDR_VOLTAGE_PEAK, {8'h00, d[31:8]});
      rdchk(ADDR_OVERCURRENT_STAT, {26'h000_0000, 3'b001 << p, 3'b000});
    end
    // asynchronous status levels settle into read-only registers
    d = rnd();
    {i_line_period, i_power_sign, i_no_load} = {d, d[5:0]};
    repeat (3) @(posedge i_ref_clk);
    host.wr(ADDR_NO_LOAD_STATUS, 32'hFFFF_FFFF);
    rdchk(ADDR_NO_LOAD_STATUS, {26'h000_0000, d[5:0]});
    rdchk(ADDR_LINE_PERIOD, {16'h0000, d[31:16]});
    rdchk(ADDR_POWER_SIGN, {16'h0000, d[15:0]});
    host.wr(16'hE605, 32'hFFFF_FFFF);
    rdchk(16'hE605, 32'h0000_0000);
    chk({31'h0000_0000, o_reg_hit}, 32'h0000_0000);
    // read-only and unmapped writes above left the eight settings checked here alone
    chk({o_zero_cross_timeout, o_computation_mode}, (mdl[2] << 16) | mdl[3]);
    chk({16'h0000, o_main_configuration}, mdl[5]);
    chk({16'h0000, o_measurement_select, o_accumulation_select}, (mdl[6] << 8) | mdl[7]);
    chk({16'h0000, o_line_accum_select, o_capture_port_config}, (mdl[8] << 8) | mdl[11]);
    chk({24'h00_0000, o_secondary_configuration}, mdl[14]);
    // select pin follows data bit 0 only while the serial port is active
    foreach (ps[k])
    begin
      i_spi_active = ps[k][1];
      d = rnd();
      host.wr(ADDR_SELECT_ACK_PIN, {d[31:1], ps[k][0]});
      chk({31'h0000_0000, o_select_ack_pin}, {31'h0000_0000, ps[k][2]});
    end
    // mid-run reset brings written settings and the pin back to defaults
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_sys_rst = 1'b0;
    rdchk(ADDR_LINE_CYCLE_COUNT, {16'h0000, RST_LINE_CYCLE_COUNT});
    chk({o_peak_half_cycles, o_sag_half_cycles, o_write_protection, 8'h00}, 32'h0000_0000);
    chk({31'h0000_0000, o_select_ack_pin}, {31'h0000_0000, RST_SELECT_ACK_PIN});
    results();
  end
endmodule
